// ===== hdl/adcc_ctrl.sv
// Purpose: control, sequencing and apb registers of an 8-bit sar converter
// Assumes: comparator answers within the same cycle as the trial code
// Notes: comparator high means the held input is at or above the trial code
`timescale 1ns/1ps

// How it works
// - conversion lasts 64 cycles, 32 sampling
// - input at top gives ffh, no overflow
// - input at bottom gives 00h
// - three-bit field selects input n
// - after power-on and settle, convert continuously
// - completion stores result, sets flag, interrupt if enabled
// - control write aborts, clears flag, restarts
// - reading result clears completion flag
// - power bit low keeps converter off
// - wait mode leaves converter running
// - halt disables, wake needs settle again
// - control bit four always reads zero
// - both registers reset to 00h
// - unsigned code scaled 255 over span
// - digital read of pins still works
module adcc_ctrl
  import adcc_pkg::*;
#(
  parameter int PIN_W = 8
) (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // low power
  input wire logic HALT_I,
  // converter core
  input wire logic COMP_I,
  output logic CORE_EN_O,
  output logic SAMPLE_O,
  output logic [2:0] CH_SEL_O,
  output logic [7:0] DAC_CODE_O,
  // digital view of the analog pins
  input wire logic [PIN_W-1:0] PIN_LEVEL_I,
  output logic [PIN_W-1:0] PIN_LEVEL_O,
  // interrupt
  output logic IRQ_O
);

  adcc_regs_t s_reg;
  adcc_regs_t s_next;
  logic acc;
  logic wr;
  logic rd;
  logic [9:0] idx;
  logic hit;
  logic csr_wr;
  logic res_rd;
  logic done;
  logic slot_end;
  logic [7:0] mask;
  logic [7:0] decided;
  logic [7:0] csr_view;

  // apb decode, zero wait states
  assign acc = PSEL_I && PENABLE_I;
  assign wr = acc && PWRITE_I;
  assign rd = acc && !PWRITE_I;
  assign idx = PADDR_I[11:2];
  assign hit = (idx == IDX_RESULT) || (idx == IDX_CSR) ||
    (idx == IDX_ISTS) || (idx == IDX_IEN) || (idx == IDX_ICLR);
  assign csr_wr = wr && (idx == IDX_CSR);
  assign res_rd = rd && (idx == IDX_RESULT);

  // sar bit slot: four cycles per bit after the sample phase
  assign mask = 8'h80 >> s_reg.cnt[4:2];
  assign slot_end = (s_reg.st == ADCC_CONV) && s_reg.cnt[5] &&
    (s_reg.cnt[1:0] == 2'h3);
  // comparator low drops the trial bit; all high saturates at ffh
  assign decided = COMP_I ? s_reg.sar : (s_reg.sar & ~mask);
  assign done = (s_reg.st == ADCC_CONV) && (s_reg.cnt == CONV_LAST) &&
    !csr_wr;

  // control/status read view, unused bits zero
  always_comb begin
    csr_view = 8'h00;
    csr_view[CSR_DONE_BIT] = s_reg.coco;
    csr_view[CSR_PWR_BIT] = s_reg.pwr;
    csr_view[CSR_ZERO_BIT] = 1'b0;
    csr_view[2:0] = s_reg.ch;
  end

  // next state of the whole block
  always_comb begin
    s_next = s_reg;
    s_next.dig = PIN_LEVEL_I;
    // sequencer
    unique case (s_reg.st)
      ADCC_OFF: begin
        s_next.stab = 10'h000;
        if (s_reg.pwr && !HALT_I) begin
          s_next.st = ADCC_SETTLE;
        end
      end
      ADCC_SETTLE: begin
        if (s_reg.stab == STAB_LAST) begin
          s_next.st = ADCC_CONV;
          s_next.cnt = 6'h00;
        end else begin
          s_next.stab = s_reg.stab + 10'h001;
        end
      end
      ADCC_CONV: begin
        s_next.cnt = s_reg.cnt + 6'h01;
        if (s_reg.cnt == SAMPLE_LAST) begin
          s_next.sar = 8'h80;
        end
        if (slot_end) begin
          s_next.sar = decided | (mask >> 1);
        end
        if (done) begin
          s_next.result = decided;
          s_next.coco = 1'b1;
          s_next.ists[IRQ_DONE] = 1'b1;
          if (s_reg.coco && !res_rd) begin
            s_next.ists[IRQ_OVWR] = 1'b1;
          end
        end
      end
      default: begin
        s_next.st = ADCC_OFF;
      end
    endcase
    // result read clears the flag unless a new result lands
    if (res_rd && !done) begin
      s_next.coco = 1'b0;
    end
    // control write aborts and restarts
    if (csr_wr) begin
      s_next.pwr = PWDATA_I[CSR_PWR_BIT];
      s_next.ch = PWDATA_I[2:0];
      s_next.coco = 1'b0;
      s_next.cnt = 6'h00;
    end
    // interrupt enable and write-one clear; a set wins only on a bit that was not already set
    if (wr && (idx == IDX_IEN)) begin
      s_next.ien = PWDATA_I[1:0];
    end
    if (wr && (idx == IDX_ICLR)) begin
      s_next.ists = s_next.ists & ~(PWDATA_I[1:0] & ~s_next.ists ^
        PWDATA_I[1:0] & ~(s_next.ists & ~s_reg.ists));
    end
    // power bit low or halt forces the converter off
    if (!s_next.pwr || HALT_I) begin
      s_next.st = ADCC_OFF;
      s_next.stab = 10'h000;
    end
  end

  // single state register
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      s_reg <= '0;
      s_reg.result <= RESULT_RST;
      s_reg.ch <= CH_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // apb answer
  always_comb begin
    PRDATA_O = 32'h0000_0000;
    if (rd) begin
      unique case (idx)
        IDX_RESULT: PRDATA_O = {24'h000000, s_reg.result};
        IDX_CSR: PRDATA_O = {24'h000000, csr_view};
        IDX_ISTS: PRDATA_O = {30'h00000000, s_reg.ists};
        IDX_IEN: PRDATA_O = {30'h00000000, s_reg.ien};
        default: PRDATA_O = 32'h0000_0000;
      endcase
    end
  end
  assign PREADY_O = acc;
  assign PSLVERR_O = acc && !hit;

  // core and pin outputs
  assign CORE_EN_O = (s_reg.st != ADCC_OFF);
  assign SAMPLE_O = (s_reg.st == ADCC_CONV) && !s_reg.cnt[5];
  assign CH_SEL_O = s_reg.ch;
  assign DAC_CODE_O = s_reg.sar;
  assign PIN_LEVEL_O = s_reg.dig;
  // wait mode has no input here, so it cannot disturb the converter
  assign IRQ_O = |(s_reg.ists & s_reg.ien);

  // assertion helpers: comparator seen high or low on every decision before the last
  logic all_hi;
  logic all_lo;
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I || (s_reg.st != ADCC_CONV) || csr_wr ||
        (s_reg.cnt == SAMPLE_LAST)) begin
      all_hi <= 1'b1;
      all_lo <= 1'b1;
    end else if (slot_end && !done) begin
      all_hi <= all_hi && COMP_I;
      all_lo <= all_lo && !COMP_I;
    end
  end

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);

  sequence s_start;
    (s_reg.st == ADCC_CONV) && (s_reg.cnt == 6'h00);
  endsequence
  sequence s_store;
    ##1 (s_reg.coco && (s_reg.result == $past(decided)));
  endsequence
  // last halt cycle followed by a powered wake without a control write
  sequence s_wake;
    HALT_I ##1 (!HALT_I && s_reg.pwr && !csr_wr);
  endsequence

  property p_conv_len;
    done |-> $past(s_reg.cnt, 63) == 6'h00 && $past(SAMPLE_O, 32) &&
      !$past(SAMPLE_O, 31);
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("conversion length wrong");

  property p_sat_hi;
    done && all_hi && COMP_I |=> s_reg.result == 8'hff;
  endproperty
  a_sat_hi: assert property (p_sat_hi)
    else $error("full-scale input not ffh");

  property p_sat_lo;
    done && all_lo && !COMP_I |=> s_reg.result == 8'h00;
  endproperty
  a_sat_lo: assert property (p_sat_lo)
    else $error("bottom input not 00h");

  property p_done;
    done |-> s_store;
  endproperty
  a_done: assert property (p_done)
    else $error("completion not stored");

  property p_abort;
    csr_wr && PWDATA_I[CSR_PWR_BIT] && (s_reg.st == ADCC_CONV) && !HALT_I
      |=> (!s_reg.coco) and s_start;
  endproperty
  a_abort: assert property (p_abort)
    else $error("control write did not restart");

  property p_rd_clr;
    res_rd && !done && !csr_wr |=> !s_reg.coco;
  endproperty
  a_rd_clr: assert property (p_rd_clr)
    else $error("result read kept flag");

  property p_off;
    !s_reg.pwr |-> !CORE_EN_O && !SAMPLE_O && !s_reg.coco;
  endproperty
  a_off: assert property (p_off)
    else $error("converter on while powered down");

  property p_halt;
    s_wake |-> !CORE_EN_O ##1
      ((s_reg.st == ADCC_SETTLE) && (s_reg.stab == 10'h000));
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt exit skipped settling");

  property p_settle;
    (s_reg.st == ADCC_CONV) && ($past(s_reg.st) == ADCC_SETTLE) |->
      $past(s_reg.stab) == STAB_LAST;
  endproperty
  a_settle: assert property (p_settle)
    else $error("settle time wrong");

  property p_bit4;
    rd && (idx == IDX_CSR) |-> PRDATA_O[CSR_ZERO_BIT] == 1'b0;
  endproperty
  a_bit4: assert property (p_bit4)
    else $error("control bit four not zero");

  property p_rst;
    $past(RST_I) |-> s_reg.result == 8'h00 && csr_view == 8'h00;
  endproperty
  a_rst: assert property (@(posedge REF_CLK_I) p_rst)
    else $error("registers not zero after reset");

  property p_pin;
    ##1 1'b1 |-> PIN_LEVEL_O == $past(PIN_LEVEL_I);
  endproperty
  a_pin: assert property (p_pin)
    else $error("pin level not passed");

  property p_ch;
    csr_wr |=> CH_SEL_O == $past(PWDATA_I[2:0]);
  endproperty
  a_ch: assert property (p_ch)
    else $error("channel select wrong");

  // helper: cycles spent in the settle state, kept apart from stab
  logic [10:0] settle_len;
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I || (s_reg.st != ADCC_SETTLE)) begin
      settle_len <= 11'h000;
    end else begin
      settle_len <= settle_len + 11'h001;
    end
  end

  // settle must last the full stabilisation span before converting
  property p_settle_len;
    (s_reg.st == ADCC_CONV) && ($past(s_reg.st) == ADCC_SETTLE) |->
      settle_len == 11'(STAB_CYC);
  endproperty
  a_settle_len: assert property (p_settle_len)
    else $error("settle length wrong");

  // a finished conversion is followed at once by the next one
  property p_cont;
    done && s_reg.pwr && !HALT_I |=> s_start;
  endproperty
  a_cont: assert property (p_cont)
    else $error("conversion not restarted");

  // first trial code after sampling is mid scale
  property p_dac_start;
    (s_reg.st == ADCC_CONV) && (s_reg.cnt == SAMPLE_LAST) |=>
      DAC_CODE_O == 8'h80;
  endproperty
  a_dac_start: assert property (p_dac_start)
    else $error("first trial code wrong");

  // powered and not halted keeps the core running
  property p_core_on;
    s_reg.pwr && !HALT_I && !csr_wr |=> CORE_EN_O;
  endproperty
  a_core_on: assert property (p_core_on)
    else $error("core off while powered");

  // halt switches the core off on the next edge
  property p_core_off;
    HALT_I |=> !CORE_EN_O;
  endproperty
  a_core_off: assert property (p_core_off)
    else $error("core on during halt");

  // clearing the power bit stops the core and drops the flag
  property p_pwr_off;
    csr_wr && !PWDATA_I[CSR_PWR_BIT] |=> !CORE_EN_O && !s_reg.coco;
  endproperty
  a_pwr_off: assert property (p_pwr_off)
    else $error("power-down write ignored");

  // completion never raises the interrupt line while both enables are clear
  property p_no_irq;
    s_reg.ien == 2'h0 |-> !IRQ_O;
  endproperty
  a_no_irq: assert property (p_no_irq)
    else $error("interrupt without enable");

  // result only changes when a conversion completes
  property p_res_hold;
    !done |=> $stable(s_reg.result);
  endproperty
  a_res_hold: assert property (p_res_hold)
    else $error("result changed without completion");

  // channel select only moves on a control write
  property p_ch_hold;
    !csr_wr |=> $stable(CH_SEL_O);
  endproperty
  a_ch_hold: assert property (p_ch_hold)
    else $error("channel select changed");

endmodule : adcc_ctrl

// ===== hdl/adcc_pkg.sv
// Purpose: shared constants and types for the converter control block
// Assumes: 20 MHz clock equal to the cpu clock, apb word registers
// Notes: register byte address is four times the register index
package adcc_pkg;
  // register indices, byte address = index * 4
  localparam logic [9:0] IDX_RESULT = 10'h070;
  localparam logic [9:0] IDX_CSR = 10'h071;
  localparam logic [9:0] IDX_ISTS = 10'h072;
  localparam logic [9:0] IDX_IEN = 10'h073;
  localparam logic [9:0] IDX_ICLR = 10'h074;
  // control/status field positions
  localparam int CSR_DONE_BIT = 7;
  localparam int CSR_PWR_BIT = 5;
  localparam int CSR_ZERO_BIT = 4;
  // values after reset
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [2:0] CH_RST = 3'h0;
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int STAB_TIME_NS = 30000;
  localparam int STAB_CYC = (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] STAB_LAST = 10'(STAB_CYC - 1);
  localparam int CONV_CYC = 64;
  localparam int SAMPLE_CYC = 32;
  localparam logic [5:0] CONV_LAST = 6'(CONV_CYC - 1);
  localparam logic [5:0] SAMPLE_LAST = 6'(SAMPLE_CYC - 1);
  // interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_OVWR = 1;
  // converter sequence, gray along off -> settle -> convert
  typedef enum logic [1:0] {
    ADCC_OFF = 2'b00,
    ADCC_SETTLE = 2'b01,
    ADCC_CONV = 2'b11
  } adcc_state_t;
  // all state of the control block
  typedef struct packed {
    adcc_state_t st;
    logic [9:0] stab;
    logic [5:0] cnt;
    logic [7:0] sar;
    logic [7:0] result;
    logic coco;
    logic pwr;
    logic [2:0] ch;
    logic [1:0] ists;
    logic [1:0] ien;
    logic [7:0] dig;
  } adcc_regs_t;
endpackage : adcc_pkg

// ===== sim/adcc_core_model.sv
// Purpose: comparator model of the sample-hold converter core
// Assumes: levels are in code units, above ff means over the top
// Notes: answer toggles every cycle while the core is off
`timescale 1ns/1ps
module adcc_core_model (
  // clock and core controls
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic sample_i,
  input wire logic [2:0] ch_i,
  input wire logic [7:0] code_i,
  // analog levels of the eight inputs
  input wire logic [8:0] lvl_i [8],
  // comparator answer
  output logic comp_o
);
  logic [8:0] held = 9'h000;
  logic tog = 1'b0;
  // follow the selected input while sampling
  always @(posedge clk_i) begin
    // pins act as plain inputs here: no pull, no pin interrupt
    if (sample_i) held <= lvl_i[ch_i];
    tog <= ~tog;
  end
  // held level at or above the trial code answers high
  assign comp_o = en_i ? (held >= {1'b0, code_i}) : tog;
endmodule : adcc_core_model

// ===== sim/tb_adc_conversion_control.sv
// Purpose: self-checking bench of the converter control block
// Assumes: zero wait apb slave, settle 600 cycles, 64 per conversion
// Notes: reads note their expected word, a monitor compares them
`timescale 1ns/1ps
module tb_adc_conversion_control
  import adcc_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wd = 32'h0, rdata, scnt = 32'h0, seed = 32'h92a7, r;
  logic [7:0] pin = 8'h00, prev = 8'h00, pin_o, code;
  logic [8:0] lvl [8];
  logic rdy, err, halt = 1'b0, comp, en, smp, irq;
  logic [2:0] ch;
  logic [31:0] q[$];
  int mismatches = 0, samples_checked = 0, cyc = 0;
  adcc_ctrl dut (.REF_CLK_I(clk), .RST_I(rst), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(addr), .PWDATA_I(wd),
    .PRDATA_O(rdata), .PREADY_O(rdy), .PSLVERR_O(err), .HALT_I(halt),
    .COMP_I(comp), .CORE_EN_O(en), .SAMPLE_O(smp), .CH_SEL_O(ch),
    .DAC_CODE_O(code), .PIN_LEVEL_I(pin), .PIN_LEVEL_O(pin_o),
    .IRQ_O(irq));
  adcc_core_model core (.clk_i(clk), .en_i(en), .sample_i(smp),
    .ch_i(ch), .code_i(code), .lvl_i(lvl), .comp_o(comp));
  // 20 mhz clock
  always #25 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic end_sim();
    if (mismatches == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  // one apb transfer, held until pready at a rising edge
  task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    addr <= {i, 2'b00};
    wd <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic rd(input logic [9:0] i, input logic [7:0] e);
    q.push_back({24'h0, e});
    apb(1'b0, i, 8'h00);
  endtask : rd
  // random pins, read data and pin echo monitor, sample length
  always @(posedge clk) begin
    seed <= xs(seed);
    pin <= seed[7:0];
    prev <= pin;
    cyc <= cyc + 1;
    if (cyc > 6) chk({24'h0, pin_o}, {24'h0, prev});
    if (psel && pen && rdy === 1'b1 && !pwr && q.size() > 0)
      chk(rdata, q.pop_front());
    // error answer only outside the mapped register indices
    if (psel && pen && rdy === 1'b1)
      chk({31'h0, err}, {31'h0, (addr[11:2] < IDX_RESULT) ||
        (addr[11:2] > IDX_ICLR)});
    // a control write restarts the sample phase, so restart the count
    scnt <= (smp && !(psel && pen && pwr && addr[11:2] == IDX_CSR)) ?
      scnt + 1 : 32'h0;
    if (!smp && scnt != 0 && en) chk(scnt, 32'(SAMPLE_CYC));
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_sim();
  end
  initial begin
    r = 32'h92a7;
    for (int i = 0; i < 8; i++) begin
      r = xs(r);
      lvl[i] = {1'b0, r[7:0]};
    end
    lvl[0] = 9'h000;
    lvl[7] = 9'h12c;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(IDX_RESULT, 8'h00);
    rd(IDX_CSR, 8'h00);
    rd(IDX_ICLR + 10'h1, 8'h00);
    apb(1'b1, IDX_IEN, 8'h01);
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, IDX_CSR, 8'h30 | 8'(c));
      rd(IDX_CSR, 8'h20 | 8'(c));
      repeat (680) @(posedge clk);
      rd(IDX_CSR, 8'ha0 | 8'(c));
      chk({31'h0, irq}, 32'h1);
      rd(IDX_RESULT, lvl[c] > 9'h0ff ? 8'hff : lvl[c][7:0]);
      rd(IDX_CSR, 8'h20 | 8'(c));
      repeat (60) @(posedge clk);
      rd(IDX_CSR, 8'ha0 | 8'(c));
      apb(1'b1, IDX_ICLR, 8'h01);
      @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      rd(IDX_ISTS, c == 0 ? 8'h00 : 8'h02);
    end
    // mask the pending completion
    repeat (70) @(posedge clk);
    apb(1'b1, IDX_IEN, 8'h00);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    // halt switches the core off, settle again after wake
    halt <= 1'b1;
    repeat (2) @(posedge clk);
    chk({31'h0, en}, 32'h0);
    rd(IDX_RESULT, 8'hff);
    halt <= 1'b0;
    repeat (500) @(posedge clk);
    rd(IDX_CSR, 8'h27);
    apb(1'b1, IDX_CSR, 8'h07);
    repeat (2) @(posedge clk);
    chk({31'h0, en}, 32'h0);
    repeat (200) @(posedge clk);
    rd(IDX_CSR, 8'h07);
    apb(1'b1, IDX_ICLR, 8'h03);
    rd(IDX_ISTS, 8'h00);
    repeat (2) @(posedge clk);
    end_sim();
  end
endmodule : tb_adc_conversion_control
